// file: include/gain_port_pkg.sv
// constants and types for the gain control serial/parallel port
package gain_port_pkg;

	// serial word layout
	localparam int WORD_BITS     = 8;
	localparam int ATTEN_BITS    = 5;
	localparam int ATTEN_LSB     = 0;
	localparam int LOW_POWER_BIT = 5;
	localparam int SYNC_BITS     = 10;

	// reset values: zero attenuation, full power
	localparam logic [7:0] WORD_RESET  = 8'h00;
	localparam logic [4:0] ATTEN_RESET = 5'h00;

	// attenuation step and span, in tenths of a dB
	localparam int ATTEN_STEP_TENTH_DB = 5;
	localparam int ATTEN_SPAN_TENTH_DB = 155;

	// power-on reset time and its cycle count at the system clock
	localparam int SYS_CLK_PERIOD_PS = 4000;
	localparam int POR_TIME_US       = 100;
	localparam int POR_CYCLES        =
		(POR_TIME_US * 1000000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
	localparam int POR_CNT_BITS      = 15;

	// stored serial word
	typedef struct packed {
		logic [1:0] spare;
		logic       low_power;
		logic [4:0] atten;
	} serial_word_t;

	// pins after synchronisation
	typedef struct packed {
		logic       cs_bar;
		logic       sclk;
		logic       sdi;
		logic       par_sel;
		logic [4:0] par_data;
		logic       rp;
	} pin_bundle_t;

endpackage : gain_port_pkg

// file: hdl/pin_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// pins and synchronised copy
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_r;

	// one pair of flops per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					meta_r[i]       <= 1'b0;
					pin_sync_out[i] <= 1'b0;
				end else begin
					meta_r[i]       <= pin_in[i];
					pin_sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync

// file: hdl/gain_control_port.sv
// gain and power-mode control port: serial shift path and parallel latch
`timescale 1ns/1ps
module gain_control_port
	import gain_port_pkg::*;
#(
	parameter int POR_WAIT = gain_port_pkg::POR_CYCLES
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// serial pins
	input  wire logic       chip_select_bar,
	input  wire logic       serial_clk,
	input  wire logic       serial_in,
	output logic            serial_out,
	output logic            serial_out_oe,
	// parallel and power pins
	input  wire logic       parallel_select,
	input  wire logic [4:0] parallel_data,
	input  wire logic       reduced_power_pin,
	// to the analog side
	output logic [4:0]      if_step_attenuator,
	output logic            low_power_mode,
	output logic            por_done
);
	import gain_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detection

	pin_bundle_t  pins_raw;
	pin_bundle_t  pins_s;
	logic         cs_d_r;
	logic         sclk_d_r;
	logic         cs_rise;
	logic         cs_fall;
	logic         sclk_rise;
	logic         sclk_fall;
	logic         cs_active;

	assign pins_raw = '{cs_bar: chip_select_bar, sclk: serial_clk, sdi: serial_in,
		par_sel: parallel_select, par_data: parallel_data, rp: reduced_power_pin};

	pin_sync #(
		.WIDTH(SYNC_BITS)
	) u_pin_sync (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.pin_in       (pins_raw),
		.pin_sync_out (pins_s)
	);

	// edge history, chip-select idle high after reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cs_d_r   <= 1'b1;
			sclk_d_r <= 1'b0;
		end else begin
			cs_d_r   <= pins_s.cs_bar;
			sclk_d_r <= pins_s.sclk;
		end
	end

	assign cs_active = !pins_s.cs_bar && !cs_d_r && por_done;
	assign cs_rise   = pins_s.cs_bar && !cs_d_r && por_done;
	assign cs_fall   = !pins_s.cs_bar && cs_d_r && por_done;
	assign sclk_rise = cs_active && pins_s.sclk && !sclk_d_r;
	assign sclk_fall = cs_active && !pins_s.sclk && sclk_d_r;

	////////////////////////////////////////////////////////////////////////
	// power-on reset timer

	logic [POR_CNT_BITS-1:0] por_cnt_r;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			por_cnt_r <= '0;
			por_done  <= 1'b0;
		end else if (!por_done) begin
			por_cnt_r <= por_cnt_r + 1'b1;
			por_done  <= (por_cnt_r == POR_CNT_BITS'(POR_WAIT - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial shift register and holding latch

	logic [7:0]   shift_r;
	serial_word_t hold_r;
	logic         so_r;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shift_r <= WORD_RESET;
		end else if (cs_fall) begin
			shift_r <= hold_r;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[6:0], pins_s.sdi};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hold_r <= WORD_RESET;
		end else if (cs_rise && !pins_s.par_sel) begin
			hold_r <= shift_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			so_r <= 1'b0;
		end else if (cs_fall) begin
			so_r <= hold_r[WORD_BITS-1];
		end else if (sclk_fall) begin
			so_r <= shift_r[WORD_BITS-1];
		end
	end

	assign serial_out    = so_r;
	assign serial_out_oe = cs_active;

	////////////////////////////////////////////////////////////////////////
	// parallel latch and output selection

	logic [4:0] par_r;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			par_r <= ATTEN_RESET;
		end else if (cs_rise && pins_s.par_sel) begin
			par_r <= pins_s.par_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			if_step_attenuator <= ATTEN_RESET;
			low_power_mode     <= 1'b0;
		end else begin
			if_step_attenuator <= pins_s.par_sel ? par_r : hold_r.atten;
			low_power_mode     <= hold_r.low_power || pins_s.rp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence burst_end_s;
		cs_rise && !pins_s.par_sel;
	endsequence

	sequence par_end_s;
		cs_rise && pins_s.par_sel;
	endsequence

	latch_on_rise_a: assert property (burst_end_s |=> hold_r == $past(shift_r))
		else $error("holding latch missed shift contents");
	hold_stable_a: assert property (!cs_rise |=> $stable(hold_r))
		else $error("holding latch changed outside chip-select rise");
	shift_msb_a: assert property (sclk_rise && !cs_fall |=>
		shift_r == {$past(shift_r[6:0]), $past(pins_s.sdi)})
		else $error("shift register did not shift msb first");
	so_fall_a: assert property (sclk_fall |=> serial_out == $past(shift_r[7]))
		else $error("serial output not updated on falling clock");
	oe_off_a: assert property (pins_s.cs_bar |-> !serial_out_oe)
		else $error("serial output driven while deselected");
	par_latch_a: assert property (par_end_s |=> par_r == $past(pins_s.par_data))
		else $error("parallel latch missed pins");
	gain_select_a: assert property (pins_s.par_sel |=> if_step_attenuator == $past(par_r))
		else $error("parallel gain not selected");
	power_mode_a: assert property (pins_s.rp |=> low_power_mode)
		else $error("reduced-power pin ignored");
	por_wait_a: assert property (!por_done |=> $stable(hold_r) && $stable(par_r))
		else $error("latch changed before power-on reset done");
	reset_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		reset |=> hold_r == WORD_RESET && par_r == ATTEN_RESET && !por_done)
		else $error("reset did not clear latches");

endmodule : gain_control_port

// file: verif/host_model.sv
// host model: serial bursts and chip-select pulses
`timescale 1ns/1ps
module host_model (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output logic      chip_select_bar,
	output logic      serial_clk,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe
);
	// link clock half period, 125 ns cycle
	localparam realtime SCLK_HALF_NS = 62.5;
	initial begin
		chip_select_bar = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic frame(input logic [15:0] d, input int n, output logic [15:0] rd,
		output logic oe);
		rd = 16'h0000;
		oe = 1'b1;
		@(posedge sys_clk) chip_select_bar <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in <= d[i];
			#(SCLK_HALF_NS);
			rd = {rd[14:0], serial_out};
			oe = oe & serial_out_oe;
			serial_clk <= 1'b1;
			#(SCLK_HALF_NS);
			serial_clk <= 1'b0;
		end
		repeat (16) @(posedge sys_clk);
		chip_select_bar <= 1'b1;
		serial_in <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask : frame
endmodule : host_model

// file: verif/testbench.sv
// self-checking bench for the gain control port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	import gain_port_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        parallel_select = 1'b0;
	logic        reduced_power_pin = 1'b0;
	logic [4:0]  parallel_data = 5'h00;
	logic [4:0]  if_step_attenuator;
	logic        chip_select_bar, serial_clk, serial_in, serial_out, serial_out_oe;
	logic        low_power_mode, por_done, oe;
	logic [15:0] rd, d;
	logic [7:0]  held = 8'h00;
	logic [31:0] seed = 32'h0001_0987;
	int          errors = 0;
	int          compares = 0;
	localparam int POR_SIM = 20;
	always #2 sys_clk = ~sys_clk;
	gain_control_port #(.POR_WAIT(POR_SIM)) DUT (.sys_clk(sys_clk), .reset(reset),
		.chip_select_bar(chip_select_bar), .serial_clk(serial_clk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.parallel_select(parallel_select), .parallel_data(parallel_data),
		.reduced_power_pin(reduced_power_pin), .if_step_attenuator(if_step_attenuator),
		.low_power_mode(low_power_mode), .por_done(por_done));
	host_model host (.sys_clk(sys_clk), .chip_select_bar(chip_select_bar),
		.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	// readback: stored word first, then the first bits sent
	function automatic logic [15:0] exp_rd(input logic [7:0] old, input logic [15:0] w,
		input int n);
		return (n == 8) ? {8'h00, old} : {old, w[15:8]};
	endfunction : exp_rd
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	// first negedge still falls before the release edge
	task automatic wait_por;
		int i;
		i = 0;
		while (por_done !== 1'b1 && i < 100) begin
			@(negedge sys_clk);
			i++;
		end
		`CHK("por wait", POR_SIM + 1, i)
	endtask : wait_por
	task automatic burst(input int n);
		seed = xs(seed);
		d = seed[15:0];
		host.frame(d, n, rd, oe);
		`CHK("readback", exp_rd(held, d, n), rd)
		`CHK("oe in burst", 1'b1, oe)
		held = d[7:0];
		`CHK("atten", held[4:0], if_step_attenuator)
		`CHK("power", held[5], low_power_mode)
		`CHK("oe idle", 1'b0, serial_out_oe)
	endtask : burst
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		wait_por();
		`CHK("atten reset", 5'h00, if_step_attenuator)
		`CHK("power reset", 1'b0, low_power_mode)
		burst(8);
		for (int k = 0; k < 5; k++) burst(8);
		burst(16);
		burst(8);
		$display("serial test done");
		seed = xs(seed);
		@(posedge sys_clk);
		parallel_select <= 1'b1;
		parallel_data <= {~held[4], seed[3:1], 1'b1};
		host.frame(16'h0000, 0, rd, oe);
		`CHK("parallel", {~held[4], seed[3:1], 1'b1}, if_step_attenuator)
		@(posedge sys_clk) parallel_select <= 1'b0;
		repeat (6) @(posedge sys_clk);
		`CHK("serial again", held[4:0], if_step_attenuator)
		$display("parallel test done");
		parallel_select <= 1'b1;
		reset <= 1'b1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		wait_por();
		held = 8'h00;
		`CHK("parallel clear", 5'h00, if_step_attenuator)
		@(posedge sys_clk) parallel_select <= 1'b0;
		reduced_power_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK("power pin", 1'b1, low_power_mode)
		reduced_power_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
		`CHK("power release", 1'b0, low_power_mode)
		burst(8);
		$display("reset test done");
		report_and_stop();
	end
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
endmodule : testbench
